// ==== src/mdu_pkg.sv ====
package mdu_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int XLEN = 32;
  localparam int ACC_PAIRS = 4;
  localparam int GPR_COUNT = 32;
  localparam int GPR_SETS = 2;
  localparam int BOOTH_A_W = 33;
  localparam int BOOTH_B_W = 17;
  localparam int BOOTH_P_W = 50;

  // ----------------------------------------------------------------
  // timing in pipeline clocks
  // ----------------------------------------------------------------
  localparam int MUL_LATENCY = 5;
  localparam int MUL_REISSUE = 1;
  localparam int MUL_STAGES = MUL_LATENCY - MUL_REISSUE;

  localparam logic [4:0] DIV_SKIP_8 = 5'h17;
  localparam logic [4:0] DIV_SKIP_16 = 5'h0f;
  localparam logic [4:0] DIV_SKIP_24 = 5'h07;
  localparam logic [4:0] DIV_SKIP_32 = 5'h00;
  localparam logic [5:0] DIV_BITS = 6'h20;

  // unsigned / signed division latency, equal to the reissue interval
  localparam logic [5:0] DIV_LAT_U8 = 6'h0c;
  localparam logic [5:0] DIV_LAT_S8 = 6'h0e;
  localparam logic [5:0] DIV_LAT_U16 = 6'h14;
  localparam logic [5:0] DIV_LAT_S16 = 6'h16;
  localparam logic [5:0] DIV_LAT_U24 = 6'h1c;
  localparam logic [5:0] DIV_LAT_S24 = 6'h1e;
  localparam logic [5:0] DIV_LAT_U32 = 6'h24;
  localparam logic [5:0] DIV_LAT_S32 = 6'h26;
  localparam logic [5:0] DIV_CNT_OFS = 6'h02;

  // ----------------------------------------------------------------
  // reset values and saturation limits
  // ----------------------------------------------------------------
  localparam logic [63:0] ACC_RST = 64'h0;
  localparam logic [31:0] WORD_RST = 32'h0;
  localparam logic [63:0] SAT_POS = 64'h0000_0000_7fff_ffff;
  localparam logic [63:0] SAT_NEG = 64'hffff_ffff_8000_0000;

  // ----------------------------------------------------------------
  // operations and states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_MULT    = 4'h0,
    OP_MULTU   = 4'h1,
    OP_MADD    = 4'h2,
    OP_MADDU   = 4'h3,
    OP_MSUB    = 4'h4,
    OP_MSUBU   = 4'h5,
    OP_MUL_GPR = 4'h6,
    OP_DIV     = 4'h7,
    OP_DIVU    = 4'h8,
    OP_MF_HIGH = 4'h9,
    OP_MF_LOW  = 4'ha,
    OP_DOT_ADD = 4'hb,
    OP_DOT_SUB = 4'hc,
    OP_DOT_SAT = 4'hd,
    OP_DSP_MUL = 4'he,
    OP_ACC_SHR = 4'hf
  } op_e;

  typedef enum logic [2:0] {
    DV_IDLE = 3'b001,
    DV_ITER = 3'b010,
    DV_HOLD = 3'b100
  } div_state_e;

endpackage

// ==== src/mdu_booth_mul.sv ====
`timescale 1ns/10ps
module mdu_booth_mul import mdu_pkg::*; (
  input wire logic [BOOTH_A_W-1:0] a_i, // signed multiplicand
  input wire logic [BOOTH_B_W-1:0] b_i, // signed 17-bit multiplier
  output logic [BOOTH_P_W-1:0] p_o      // signed product
);

  // ----------------------------------------------------------------
  // radix-4 recoding, nine digits
  // ----------------------------------------------------------------
  logic [BOOTH_B_W+1:0] ext;
  logic [BOOTH_P_W-1:0] a_ext;
  logic [BOOTH_P_W-1:0] pp;
  logic [BOOTH_P_W-1:0] sum;
  logic [2:0] trip;

  always_comb begin
    ext = {b_i[BOOTH_B_W-1], b_i, 1'b0};
    a_ext = {{(BOOTH_P_W-BOOTH_A_W){a_i[BOOTH_A_W-1]}}, a_i};
    sum = '0;
    pp = '0;
    trip = 3'h0;
    for (int i = 0; i < (BOOTH_B_W + 1) / 2; i++) begin
      trip = ext[2*i +: 3];
      case (trip)
        3'b001, 3'b010: pp = a_ext;
        3'b011: pp = a_ext << 1;
        3'b100: pp = -(a_ext << 1);
        3'b101, 3'b110: pp = -a_ext;
        default: pp = '0;
      endcase
      sum = sum + (pp << (2 * i)); // [RL2]
    end
    p_o = sum;
  end

endmodule

// ==== src/mdu_divider.sv ====
`timescale 1ns/10ps
module mdu_divider import mdu_pkg::*; (
  input wire logic clk_i,              // core clock
  input wire logic rst_n_i,            // sync reset, active low
  input wire logic start_i,            // divide taken this cycle
  input wire logic signed_i,           // signed form
  input wire logic [31:0] dividend_i,  // first source operand
  input wire logic [31:0] divisor_i,   // second source operand
  output logic busy_o,                 // divide in progress
  output logic done_o,                 // result ready this cycle
  output logic [31:0] quot_o,          // quotient
  output logic [31:0] rem_o            // remainder
);

  div_state_e st_q, st_d;
  logic [31:0] r_q, r_d, d_q, d_d, dsr_q, dsr_d;
  logic [5:0] it_q, it_d, cnt_q, cnt_d;
  logic qneg_q, qneg_d, rneg_q, rneg_d;
  logic [31:0] abs_dvd, abs_dsr;
  logic [32:0] sh, diff;
  logic [4:0] skip;
  logic [5:0] lat;
  logic f8, f16, f24;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    r_d = r_q;
    d_d = d_q;
    dsr_d = dsr_q;
    it_d = it_q;
    cnt_d = (cnt_q != 6'h0) ? cnt_q - 6'h1 : cnt_q;
    qneg_d = qneg_q;
    rneg_d = rneg_q;
    abs_dvd = (signed_i && dividend_i[31]) ? -dividend_i : dividend_i;
    abs_dsr = (signed_i && divisor_i[31]) ? -divisor_i : divisor_i;
    if (signed_i) begin
      f8 = (&dividend_i[31:7]) | ~(|dividend_i[31:7]);
      f16 = (&dividend_i[31:15]) | ~(|dividend_i[31:15]);
      f24 = (&dividend_i[31:23]) | ~(|dividend_i[31:23]);
    end else begin
      f8 = ~(|dividend_i[31:8]);
      f16 = ~(|dividend_i[31:16]);
      f24 = ~(|dividend_i[31:24]);
    end
    // larger latency figure taken as the signed form [RL15]
    if (f8) begin
      skip = DIV_SKIP_8; // [RL5]
      lat = signed_i ? DIV_LAT_S8 : DIV_LAT_U8; // [RL8]
    end else if (f16) begin
      skip = DIV_SKIP_16; // [RL5]
      lat = signed_i ? DIV_LAT_S16 : DIV_LAT_U16; // [RL8]
    end else if (f24) begin
      skip = DIV_SKIP_24; // [RL5]
      lat = signed_i ? DIV_LAT_S24 : DIV_LAT_U24; // [RL8]
    end else begin
      skip = DIV_SKIP_32;
      lat = signed_i ? DIV_LAT_S32 : DIV_LAT_U32; // [RL8]
    end
    sh = {r_q, d_q[31]};
    diff = sh - {1'b0, dsr_q};
    case (st_q)
      DV_IDLE: begin
        if (start_i) begin
          d_d = abs_dvd << skip; // [RL5]
          r_d = WORD_RST;
          dsr_d = abs_dsr;
          it_d = DIV_BITS - {1'b0, skip};
          cnt_d = lat - DIV_CNT_OFS; // [RL8]
          qneg_d = signed_i & (dividend_i[31] ^ divisor_i[31]);
          rneg_d = signed_i & dividend_i[31];
          st_d = DV_ITER;
        end
      end
      DV_ITER: begin
        if (it_q != 6'h0) begin
          it_d = it_q - 6'h1;
          if (!diff[32]) begin // one quotient bit per clock [RL4]
            r_d = diff[31:0];
            d_d = {d_q[30:0], 1'b1};
          end else begin
            r_d = sh[31:0];
            d_d = {d_q[30:0], 1'b0};
          end
        end else begin
          d_d = qneg_q ? -d_q : d_q;
          r_d = rneg_q ? -r_q : r_q;
          st_d = DV_HOLD;
        end
      end
      DV_HOLD: begin
        if (cnt_q == 6'h0) begin
          st_d = DV_IDLE;
        end
      end
      default: st_d = DV_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= DV_IDLE;
      r_q <= WORD_RST;
      d_q <= WORD_RST;
      dsr_q <= WORD_RST;
      it_q <= 6'h0;
      cnt_q <= 6'h0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      r_q <= r_d;
      d_q <= d_d;
      dsr_q <= dsr_d;
      it_q <= it_d;
      cnt_q <= cnt_d;
      qneg_q <= qneg_d;
      rneg_q <= rneg_d;
    end
  end

  assign busy_o = (st_q != DV_IDLE);
  assign done_o = (st_q == DV_HOLD) && (cnt_q == 6'h0);
  assign quot_o = d_q;
  assign rem_o = r_q;

endmodule

// ==== src/mul_div_unit.sv ====
`timescale 1ns/10ps
// Overview of operation
// RL1: own pipeline beside the integer pipe; keeps advancing when it stalls.
// RL2: Booth-recoded 32x16 array: full first operand, 16 bits of second.
// RL3: a new multiply or multiply-accumulate is accepted every clock.
// RL4: divider is iterative, one quotient bit per clock.
// RL5: early-in skips 23, 15 or 7 iterations for 8, 16, 24-bit dividends.
// RL6: any unit operation issued during a divide stalls the pipe until done.
// RL7: pair, accumulate, subtract, register multiplies: latency 5, reissue 1.
// RL8: divide latency 12/14, 20/22, 28/30, 36/38 by dividend width.
// RL9: results go to one of four high/low pairs; moves copy words out.
// RL10: register-destination multiply puts the low product word in a register.
// RL11: multiply-add adds, multiply-subtract subtracts product; same pair.
// RL12: accumulator shifts and DSP multiplies; three pairs beyond the base pair.
// RL13: DSP multiply and dot-product, saturating or not: latency 5, reissue 1.
// RL14: register file 32x32 plus shadow set, two reads, one write, bypassed.
// RL15: larger divide latency figure is the signed form.
module mul_div_unit import mdu_pkg::*; (
  input wire logic CLK_I,               // core clock
  input wire logic RSTN_I,              // sync reset, active low
  input wire logic ISSUE_VALID_I,       // integer_pipe offers an operation
  input wire logic [3:0] ISSUE_OP_I,    // operation code (op_e)
  input wire logic [1:0] ISSUE_ACC_I,   // accumulator pair select
  input wire logic [4:0] ISSUE_DEST_I,  // general_register destination
  input wire logic [31:0] SRC1_I,       // first_source_operand
  input wire logic [31:0] SRC2_I,       // second_source_operand
  output logic STALL_O,                 // hold integer_pipe
  output logic DIV_BUSY_O,              // divide in progress
  input wire logic SHADOW_SET_I,        // register set in use
  input wire logic [4:0] RD_ADDR_A_I,   // read port a address
  input wire logic [4:0] RD_ADDR_B_I,   // read port b address
  output logic [31:0] RD_DATA_A_O,      // read port a data
  output logic [31:0] RD_DATA_B_O,      // read port b data
  input wire logic PIPE_WE_I,           // integer_pipe write request
  input wire logic [4:0] PIPE_WADDR_I,  // integer_pipe write address
  input wire logic [31:0] PIPE_WDATA_I, // integer_pipe write data
  output logic PIPE_WREADY_O,           // write port free for the pipe
  output logic RES_WE_O,                // unit writes a register
  output logic [5:0] RES_ADDR_O,        // {set, index} written
  output logic [31:0] RES_DATA_O        // data written
);

  typedef struct packed {
    op_e op;
    logic [1:0] acc;
    logic [4:0] dest;
    logic set;
    logic [5:0] shamt;
  } meta_s;

  localparam int ST = MUL_STAGES;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [ST:1] vld_q, vld_d;
  meta_s meta_q [1:ST];
  meta_s meta_d [1:ST];
  logic [31:0] s1a_q, s1a_d, s1b_q, s1b_d;
  logic [BOOTH_P_W-1:0] pa_q, pa_d, pb_q, pb_d;
  logic [63:0] p3_q, p3_d, p4_q, p4_d;
  logic [63:0] acc_q [0:ACC_PAIRS-1];
  logic [63:0] acc_d [0:ACC_PAIRS-1];
  logic [1:0] dacc_q, dacc_d;
  logic res_we_q, res_we_d;
  logic [5:0] res_addr_q, res_addr_d;
  logic [31:0] res_data_q, res_data_d;
  logic [31:0] gpr_mem [0:GPR_SETS*GPR_COUNT-1];
  logic [31:0] rda_q, rda_d, rdb_q, rdb_d;

  // ----------------------------------------------------------------
  // issue
  // ----------------------------------------------------------------
  op_e op_in;
  logic is_div, take, div_busy, div_done;
  logic [31:0] div_quot, div_rem;

  assign op_in = op_e'(ISSUE_OP_I);
  assign is_div = (op_in == OP_DIV) || (op_in == OP_DIVU);
  assign take = ISSUE_VALID_I & ~div_busy; // [RL3]
  assign STALL_O = ISSUE_VALID_I & div_busy; // [RL6]
  assign DIV_BUSY_O = div_busy;

  mdu_divider u_div (
    .clk_i(CLK_I),
    .rst_n_i(RSTN_I),
    .start_i(take & is_div),
    .signed_i(op_in == OP_DIV),
    .dividend_i(SRC1_I),
    .divisor_i(SRC2_I),
    .busy_o(div_busy),
    .done_o(div_done),
    .quot_o(div_quot),
    .rem_o(div_rem)
  );

  // ----------------------------------------------------------------
  // booth array inputs
  // ----------------------------------------------------------------
  op_e op1;
  logic sg1, dsp1;
  logic [BOOTH_A_W-1:0] ba_lo, ba_hi;
  logic [BOOTH_B_W-1:0] bb_lo, bb_hi;
  logic [BOOTH_P_W-1:0] bp_lo, bp_hi;

  always_comb begin
    op1 = meta_q[1].op;
    sg1 = !(op1 == OP_MULTU || op1 == OP_MADDU || op1 == OP_MSUBU);
    dsp1 = (op1 == OP_DOT_ADD) || (op1 == OP_DOT_SUB) ||
           (op1 == OP_DOT_SAT) || (op1 == OP_DSP_MUL);
    if (dsp1) begin // halfword lanes for DSP forms [RL13]
      ba_lo = {{17{s1a_q[15]}}, s1a_q[15:0]};
      bb_lo = {s1b_q[15], s1b_q[15:0]};
      ba_hi = {{17{s1a_q[31]}}, s1a_q[31:16]};
      bb_hi = {s1b_q[31], s1b_q[31:16]};
    end else begin // full 32-bit operand times two 16-bit halves [RL2]
      ba_lo = {sg1 & s1a_q[31], s1a_q};
      bb_lo = {1'b0, s1b_q[15:0]};
      ba_hi = {sg1 & s1a_q[31], s1a_q};
      bb_hi = {sg1 & s1b_q[31], s1b_q[31:16]};
    end
  end

  mdu_booth_mul u_mul_lo (
    .a_i(ba_lo),
    .b_i(bb_lo),
    .p_o(bp_lo)
  );

  mdu_booth_mul u_mul_hi (
    .a_i(ba_hi),
    .b_i(bb_hi),
    .p_o(bp_hi)
  );

  // ----------------------------------------------------------------
  // product combine and accumulate
  // ----------------------------------------------------------------
  logic [63:0] pa64, pb64, cur, sum, dif, shr, acc_new;
  logic [5:0] neg_amt;
  meta_s m4;
  logic wr_acc, wr_gpr;
  logic [31:0] gpr_val;

  always_comb begin
    pa64 = {{(64-BOOTH_P_W){pa_q[BOOTH_P_W-1]}}, pa_q};
    pb64 = {{(64-BOOTH_P_W){pb_q[BOOTH_P_W-1]}}, pb_q};
    case (meta_q[2].op)
      OP_DSP_MUL: p3_d = {pb_q[31:0], pa_q[31:0]}; // [RL13]
      OP_DOT_ADD, OP_DOT_SUB, OP_DOT_SAT: p3_d = pa64 + pb64; // [RL13]
      default: p3_d = pa64 + (pb64 << 16); // [RL2]
    endcase
    p4_d = p3_q;
    m4 = meta_q[ST];
    cur = acc_q[m4.acc]; // last stage write forwards to the next op
    sum = cur + p4_q;
    dif = cur - p4_q;
    neg_amt = -m4.shamt;
    if (m4.shamt[5]) begin
      shr = cur << neg_amt;
    end else begin
      shr = $signed(cur) >>> m4.shamt;
    end
    acc_new = cur;
    wr_acc = 1'b1;
    wr_gpr = 1'b0;
    gpr_val = WORD_RST;
    case (m4.op)
      OP_MULT, OP_MULTU: acc_new = p4_q; // [RL9]
      OP_MADD, OP_MADDU: acc_new = sum; // [RL11]
      OP_MSUB, OP_MSUBU: acc_new = dif; // [RL11]
      OP_DOT_ADD: acc_new = sum; // [RL13]
      OP_DOT_SUB: acc_new = dif; // [RL13]
      OP_DOT_SAT: begin // clamp to a signed word [RL13]
        if (!sum[63] && (sum > SAT_POS)) begin
          acc_new = SAT_POS;
        end else if (sum[63] && (sum < SAT_NEG)) begin
          acc_new = SAT_NEG;
        end else begin
          acc_new = sum;
        end
      end
      OP_DSP_MUL: acc_new = p4_q; // [RL13]
      OP_ACC_SHR: acc_new = shr; // [RL12]
      OP_MUL_GPR: begin // low word straight to a register [RL10]
        wr_acc = 1'b0;
        wr_gpr = 1'b1;
        gpr_val = p4_q[31:0];
      end
      OP_MF_HIGH: begin // move_from_acc_high [RL9]
        wr_acc = 1'b0;
        wr_gpr = 1'b1;
        gpr_val = cur[63:32];
      end
      OP_MF_LOW: begin // move_from_acc_low [RL9]
        wr_acc = 1'b0;
        wr_gpr = 1'b1;
        gpr_val = cur[31:0];
      end
      default: wr_acc = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // pipeline next values
  // ----------------------------------------------------------------
  always_comb begin
    // no stall input: the stages shift every clock [RL1]
    vld_d = {vld_q[ST-1:1], take & ~is_div}; // [RL3] [RL7]
    meta_d[1] = '{op: op_in, acc: ISSUE_ACC_I, dest: ISSUE_DEST_I,
                  set: SHADOW_SET_I, shamt: SRC1_I[5:0]};
    for (int i = 2; i <= ST; i++) begin
      meta_d[i] = meta_q[i-1];
    end
    s1a_d = SRC1_I;
    s1b_d = SRC2_I;
    pa_d = bp_lo;
    pb_d = bp_hi;
    dacc_d = (take & is_div) ? ISSUE_ACC_I : dacc_q;
    for (int i = 0; i < ACC_PAIRS; i++) begin
      acc_d[i] = acc_q[i];
    end
    if (vld_q[ST] && wr_acc) begin
      acc_d[m4.acc] = acc_new; // visible 5 clocks after issue [RL7]
    end
    if (div_done) begin
      acc_d[dacc_q] = {div_rem, div_quot}; // [RL9] [RL8]
    end
    res_we_d = vld_q[ST] & wr_gpr; // [RL7] [RL10]
    res_addr_d = {m4.set, m4.dest};
    res_data_d = gpr_val;
  end

  // ----------------------------------------------------------------
  // register file: two read ports, one write port, bypassed
  // ----------------------------------------------------------------
  logic w_en;
  logic [5:0] w_addr, ra_a, ra_b;
  logic [31:0] w_data;

  always_comb begin
    w_en = res_we_q | PIPE_WE_I;
    w_addr = res_we_q ? res_addr_q : {SHADOW_SET_I, PIPE_WADDR_I};
    w_data = res_we_q ? res_data_q : PIPE_WDATA_I;
    ra_a = {SHADOW_SET_I, RD_ADDR_A_I};
    ra_b = {SHADOW_SET_I, RD_ADDR_B_I};
    rda_d = (w_en && (w_addr == ra_a)) ? w_data : gpr_mem[ra_a]; // [RL14]
    rdb_d = (w_en && (w_addr == ra_b)) ? w_data : gpr_mem[ra_b]; // [RL14]
  end

  always_ff @(posedge CLK_I) begin
    if (w_en) begin
      gpr_mem[w_addr] <= w_data; // [RL14]
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      vld_q <= '0;
      for (int i = 1; i <= ST; i++) begin
        meta_q[i] <= '0;
      end
      s1a_q <= WORD_RST;
      s1b_q <= WORD_RST;
      pa_q <= '0;
      pb_q <= '0;
      p3_q <= ACC_RST;
      p4_q <= ACC_RST;
      for (int i = 0; i < ACC_PAIRS; i++) begin
        acc_q[i] <= ACC_RST;
      end
      dacc_q <= 2'h0;
      res_we_q <= 1'b0;
      res_addr_q <= 6'h0;
      res_data_q <= WORD_RST;
      rda_q <= WORD_RST;
      rdb_q <= WORD_RST;
    end else begin
      vld_q <= vld_d;
      for (int i = 1; i <= ST; i++) begin
        meta_q[i] <= meta_d[i];
      end
      s1a_q <= s1a_d;
      s1b_q <= s1b_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      p3_q <= p3_d;
      p4_q <= p4_d;
      for (int i = 0; i < ACC_PAIRS; i++) begin
        acc_q[i] <= acc_d[i];
      end
      dacc_q <= dacc_d;
      res_we_q <= res_we_d;
      res_addr_q <= res_addr_d;
      res_data_q <= res_data_d;
      rda_q <= rda_d;
      rdb_q <= rdb_d;
    end
  end

  assign PIPE_WREADY_O = ~res_we_q;
  assign RES_WE_O = res_we_q;
  assign RES_ADDR_O = res_addr_q;
  assign RES_DATA_O = res_data_q;
  assign RD_DATA_A_O = rda_q;
  assign RD_DATA_B_O = rdb_q;

endmodule

// ==== testbench/mdu_checker_assertions.sv ====
`timescale 1ns/10ps
module mdu_checker import mdu_pkg::*; (
  input wire logic CLK_I,              // core clock
  input wire logic RSTN_I,             // sync reset, active low
  input wire logic ISSUE_VALID_I,      // op offered
  input wire logic [3:0] ISSUE_OP_I,   // op code
  input wire logic [4:0] ISSUE_DEST_I, // destination index
  input wire logic [31:0] SRC1_I,      // dividend
  input wire logic SHADOW_SET_I,       // register set
  input wire logic STALL_O,            // pipe hold
  input wire logic DIV_BUSY_O,         // divide busy
  input wire logic PIPE_WREADY_O,      // write port free
  input wire logic RES_WE_O,           // unit write
  input wire logic [5:0] RES_ADDR_O    // unit write address
);
  // ----------------------------------------------------------------
  // issue decode
  // ----------------------------------------------------------------
  logic take;
  logic wr_issue;
  assign take = ISSUE_VALID_I && !STALL_O;
  assign wr_issue = take && (ISSUE_OP_I == OP_MUL_GPR ||
    ISSUE_OP_I == OP_MF_HIGH || ISSUE_OP_I == OP_MF_LOW);

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_stall_when_busy: assert property (
    ISSUE_VALID_I && DIV_BUSY_O |-> STALL_O)
    else $error("no stall during divide");
  a_stall_only_busy: assert property (
    STALL_O |-> ISSUE_VALID_I && DIV_BUSY_O)
    else $error("stall without divide");
  a_div_sets_busy: assert property (take && (ISSUE_OP_I == OP_DIV ||
    ISSUE_OP_I == OP_DIVU) |=> DIV_BUSY_O)
    else $error("divide did not start");
  a_divu_short_lat: assert property (take && ISSUE_OP_I == OP_DIVU &&
    SRC1_I[31:8] == 24'h0 |=> DIV_BUSY_O [*8] ##1 DIV_BUSY_O [*3]
    ##1 !DIV_BUSY_O)
    else $error("unsigned 8-bit divide latency wrong");
  a_div_short_lat: assert property (take && ISSUE_OP_I == OP_DIV &&
    (&SRC1_I[31:7] || ~|SRC1_I[31:7]) |=> DIV_BUSY_O [*8]
    ##1 DIV_BUSY_O [*5] ##1 !DIV_BUSY_O)
    else $error("signed 8-bit divide latency wrong");
  a_div_bounded: assert property (
    $rose(DIV_BUSY_O) |-> ##[1:37] !DIV_BUSY_O)
    else $error("divide too long");
  a_gpr_mul_write: assert property (
    take && ISSUE_OP_I == OP_MUL_GPR |-> ##5 RES_WE_O &&
    RES_ADDR_O == {$past(SHADOW_SET_I, 5), $past(ISSUE_DEST_I, 5)})
    else $error("register multiply write wrong");
  a_move_latency: assert property (take && (ISSUE_OP_I == OP_MF_HIGH ||
    ISSUE_OP_I == OP_MF_LOW) |-> ##5 RES_WE_O)
    else $error("move result late");
  a_no_stray_write: assert property (
    RES_WE_O |-> $past(wr_issue, 5))
    else $error("unexpected register write");
  a_port_priority: assert property (PIPE_WREADY_O != RES_WE_O)
    else $error("write port arbitration wrong");

  c_stall: cover property (STALL_O);
  c_div_done: cover property ($fell(DIV_BUSY_O));
  c_gpr_write: cover property (RES_WE_O);
endmodule

bind mul_div_unit mdu_checker mdu_checker_inst (.*);

// ==== testbench/pipe_model.sv ====
`timescale 1ns/10ps
module pipe_model import mdu_pkg::*; (
  input wire logic clk_i,     // core clock
  input wire logic stall_i,   // unit holds the pipe
  output logic valid_o,       // op offered
  output logic [3:0] op_o,    // op code
  output logic [1:0] acc_o,   // pair select
  output logic [4:0] dest_o,  // destination
  output logic [31:0] src1_o, // first operand
  output logic [31:0] src2_o  // second operand
);
  initial begin
    valid_o = 1'b0;
    op_o = 4'h0;
    acc_o = 2'h0;
    dest_o = 5'h0;
    src1_o = 32'h0;
    src2_o = 32'h0;
  end

  // ----------------------------------------------------------------
  // issue, held until taken
  // ----------------------------------------------------------------
  task automatic issue(input logic [3:0] op, input logic [1:0] acc,
      input logic [4:0] dest, input logic [31:0] a, input logic [31:0] b);
    valid_o <= 1'b1;
    op_o <= op;
    acc_o <= acc;
    dest_o <= dest;
    src1_o <= a;
    src2_o <= b;
    @(posedge clk_i);
    while (stall_i) @(posedge clk_i);
  endtask

  // released operands do not keep the last value
  task automatic idle();
    valid_o <= 1'b0;
    src1_o <= ~src1_o;
    src2_o <= ~src2_o;
  endtask
endmodule

// ==== testbench/mul_div_unit_tb.sv ====
`timescale 1ns/10ps
module mul_div_unit_tb import mdu_pkg::*; ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic iv, stall, busy, shadow, pwe, wready, rwe;
  logic [3:0] iop;
  logic [1:0] iacc;
  logic [4:0] idst, ra, rb, pwa;
  logic [31:0] s1, s2, rda, rdb, pwd, rdat;
  logic [5:0] radr;
  logic [31:0] res_q[$];
  logic [63:0] e[4];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  mul_div_unit mul_div_unit_inst (.CLK_I(clk), .RSTN_I(rstn),
    .ISSUE_VALID_I(iv), .ISSUE_OP_I(iop), .ISSUE_ACC_I(iacc),
    .ISSUE_DEST_I(idst), .SRC1_I(s1), .SRC2_I(s2), .STALL_O(stall),
    .DIV_BUSY_O(busy), .SHADOW_SET_I(shadow), .RD_ADDR_A_I(ra),
    .RD_ADDR_B_I(rb), .RD_DATA_A_O(rda), .RD_DATA_B_O(rdb),
    .PIPE_WE_I(pwe), .PIPE_WADDR_I(pwa), .PIPE_WDATA_I(pwd),
    .PIPE_WREADY_O(wready), .RES_WE_O(rwe), .RES_ADDR_O(radr),
    .RES_DATA_O(rdat));

  pipe_model pm (.clk_i(clk), .stall_i(stall), .valid_o(iv), .op_o(iop),
    .acc_o(iacc), .dest_o(idst), .src1_o(s1), .src2_o(s2));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rwe === 1'b1) res_q.push_back(rdat);
    if (cyc > 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_rate();
    int tp;
    for (int o = 0; o < 16; o++) begin
      if (o == 7 || o == 8) continue;
      tp = cyc;
      pm.issue(4'(o), 2'(o), 5'h3, 32'h00010000 + 32'(o), 32'hffff0003);
      chk(32'(cyc - tp), 32'h1);
    end
    pm.idle();
    repeat (7) @(posedge clk);
    res_q.delete();
  endtask

  task automatic t_acc();
    logic [31:0] a, b;
    for (int k = 0; k < 4; k++) begin
      a = 32'hfff00001 + 32'(k);
      b = 32'h00012345 + 32'(k);
      e[k] = (k == 3) ? 64'(a) * 64'(b) : 64'($signed(a)) * 64'($signed(b));
      pm.issue(k == 3 ? OP_MULTU : OP_MULT, 2'(k), 5'h0, a, b);
    end
    pm.issue(OP_MADD, 2'h1, 5'h0, 32'h7fffffff, 32'hffff8000);
    pm.issue(OP_MSUB, 2'h1, 5'h0, 32'h00010001, 32'hfffffffe);
    e[1] += 64'sh7fffffff * -64'sh8000;
    e[1] -= 64'sh10001 * -64'sh2;
    for (int k = 0; k < 4; k++) begin
      pm.issue(OP_MF_HIGH, 2'(k), 5'h1, 32'h0, 32'h0);
      pm.issue(OP_MF_LOW, 2'(k), 5'h2, 32'h0, 32'h0);
    end
    pm.idle();
    repeat (7) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      chk(res_q.pop_front(), e[k][63:32]);
      chk(res_q.pop_front(), e[k][31:0]);
    end
  endtask

  task automatic t_gpr();
    logic [63:0] p;
    p = 64'($signed(32'h00123456)) * 64'($signed(32'hfedcba98));
    shadow <= 1'b1;
    rb <= 5'h5;
    pm.issue(OP_MUL_GPR, 2'h0, 5'h5, 32'h00123456, 32'hfedcba98);
    pm.issue(OP_MF_LOW, 2'h0, 5'h6, 32'h0, 32'h0);
    pm.idle();
    repeat (7) @(posedge clk);
    chk(res_q.pop_front(), p[31:0]);
    chk(res_q.pop_front(), e[0][31:0]);
    chk(rdb, p[31:0]);
    shadow <= 1'b0;
  endtask

  task automatic t_regfile();
    pwe <= 1'b1;
    pwa <= 5'h9;
    pwd <= 32'h5a5a0009;
    ra <= 5'h9;
    @(posedge clk);
    pwe <= 1'b0;
    @(posedge clk);
    chk(rda, 32'h5a5a0009);
  endtask

  task automatic t_div();
    logic [31:0] dv [8] = '{32'h000000c8, 32'hffffff85, 32'h00001234,
      32'hffff8001, 32'h00abcdef, 32'hff812345, 32'h87654321, 32'h87654321};
    logic [5:0] lt [8] = '{DIV_LAT_U8, DIV_LAT_S8, DIV_LAT_U16, DIV_LAT_S16,
      DIV_LAT_U24, DIV_LAT_S24, DIV_LAT_U32, DIV_LAT_S32};
    int t0, t1, sq;
    for (int i = 0; i < 8; i++) begin
      sq = dv[i];
      pm.issue(i[0] ? OP_DIV : OP_DIVU, 2'h2, 5'h0, dv[i], 32'h7);
      t0 = cyc;
      pm.issue(OP_MF_LOW, 2'h2, 5'h1, 32'h0, 32'h0);
      t1 = cyc;
      pm.issue(OP_MF_HIGH, 2'h2, 5'h2, 32'h0, 32'h0);
      pm.idle();
      repeat (7) @(posedge clk);
      chk(32'(t1 - t0), 32'(lt[i]));
      chk(res_q.pop_front(), i[0] ? 32'(sq / 7) : dv[i] / 32'h7);
      chk(res_q.pop_front(), i[0] ? 32'(sq % 7) : dv[i] % 32'h7);
    end
  endtask

  initial begin
    shadow = 1'b0;
    ra = 5'h0;
    rb = 5'h0;
    pwe = 1'b0;
    pwa = 5'h0;
    pwd = 32'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_rate();
    t_acc();
    t_gpr();
    t_regfile();
    t_div();
    stop_test();
  end
endmodule
